// ### verilog/vss_pkg.sv
package vss_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned DRIVER_ON_DELAY_US      = 117;
    localparam int unsigned DRIVER_ON_DELAY_CYC     = DRIVER_ON_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned READY_MAX_US       = 2500;
    localparam int unsigned READY_MAX_CYC      = READY_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned GLITCH_MAX_NS      = 1000;
    localparam int unsigned GLITCH_CYC         = GLITCH_MAX_NS / CLK_PERIOD_NS - 4;
    localparam int unsigned READY_DROP_MAX_NS  = 500;
    localparam int unsigned READY_DROP_CYC     = READY_DROP_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned STRAP_START_US     = 1500;
    localparam int unsigned STRAP_START_CYC    = STRAP_START_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned STRAP_MEAS_US      = 100;
    localparam int unsigned STRAP_MEAS_CYC     = STRAP_MEAS_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned MIN_PULSE_NS       = 40;
    localparam int unsigned MIN_PULSE_CYC      = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Capability formula: R[ohm] * 10uA * 255 / 2.5V = R * 255 / 250000
    localparam int unsigned CAP_NUM            = 255;
    localparam int unsigned CAP_DEN            = 250000;
    // Register offsets and power monitor bus address
    localparam logic [7:0]  REG_OUT_CURRENT    = 8'h15;
    localparam logic [7:0]  REG_OUT_POWER      = 8'h18;
    localparam logic [7:0]  REG_CAPABILITY     = 8'h21;
    localparam logic [7:0]  REG_SCALING        = 8'h50;
    localparam logic [7:0]  POWER_MON_ADDR     = 8'h0D;
    // Scaling field values
    localparam logic [1:0]  SCL_CUR_SINGLE     = 2'h0;
    localparam logic [1:0]  SCL_CUR_DOUBLE     = 2'h1;
    localparam logic [2:0]  SCL_PWR_SINGLE     = 3'h2;
    localparam logic [2:0]  SCL_PWR_DOUBLE     = 3'h3;
    // PWM tri-level codes
    localparam logic [1:0]  PWM_LOW            = 2'h0;
    localparam logic [1:0]  PWM_MID            = 2'h1;
    localparam logic [1:0]  PWM_HIGH           = 2'h2;
    localparam int unsigned NUM_RAILS          = 2;
    localparam int unsigned NUM_PHASES         = 4;
    typedef enum logic [2:0] {
        VSS_LOCKOUT, VSS_WAIT_STRAP, VSS_MEASURE, VSS_IDLE, VSS_ENABLE_WAIT, VSS_RAMP, VSS_RUN
    } vss_state_t;
endpackage : vss_pkg

// ### verilog/vss_sequencer.sv
// Contract
// R1: After supply lockout clears, capture configuration and park all PWM outputs at mid.
// R2: Raise driver_on about 117 us after rail_enable rises.
// R3: After enable, step reference DAC from zero to boot voltage at strap slew.
// R4: Each rail's PWM leaves mid only at that rail's first PWM pulse.
// R5: On disable, all PWM outputs return to mid level.
// R6: Assert regulator_ready no later than 2.5 ms after rail_enable.
// R7: Glitch-filter rail_enable fall; recognise de-assertion within 1 us.
// R8: Drop regulator_ready within 500 ns of internal enable de-assertion.
// R9: Strap detection starts 1.5 ms after lockout clears and lasts 100 us.
// R10: Phase count comes from sense inputs; board pulls unused ones to supply.
// R11: Power input tied high at start-up disables monitor; address 0Dh ignored.
// R12: Strap voltages select bus address, slew rate, boot voltage, voltage step.
// R13: Base variant keeps fast voltage mode off; other variant takes it from strap.
// R14: Capability register 21h loads strap R times 10 uA times 255 over 2.5 V.
// R15: Scaling register 50h reads 01/011 with double select on, else 00/010.
// R16: Double select on means 2 A and 8 W per bit, else 1 A, 4 W.
// R17: Never issue a PWM high pulse shorter than 40 ns; disable and lockout end a high pulse at the next clock, however short.
// R18: Strap values captured once per power-up, held until lockout returns.
// R19: Capability and scaling registers read fixed values; writes are ignored.
`timescale 1ns/10ps
module vss_sequencer
    import vss_pkg::*;
#(
    parameter int unsigned DRIVER_ON_CYC       = DRIVER_ON_DELAY_CYC,
    parameter int unsigned STRAP_WAIT_CYC = STRAP_START_CYC,
    parameter int unsigned STRAP_CYC      = STRAP_MEAS_CYC,
    parameter bit          VARIANT_R      = 1'b0
) (
    // Clock and power-on reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // Supply and enable pins
    input  wire logic              i_supply_ok,
    input  wire logic              i_rail_enable,
    // Strap measurements (capability strap in ohms, others as select codes or levels, digitised externally)
    input  wire logic [17:0]       i_strap_cap_ohm,
    input  wire logic [3:0]        i_strap_addr_slew,
    input  wire logic [3:0]        i_strap_boot_step,
    input  wire logic              i_double_current_lsb_select,
    input  wire logic              i_phase_sense_input_high [NUM_PHASES],
    input  wire logic              i_system_power_input_high,
    // PWM modulator demand per rail
    input  wire logic [NUM_RAILS-1:0] i_pwm_demand,
    // Register port: reads, and writes that are acknowledged but ignored
    input  wire logic              i_reg_rd,
    input  wire logic              i_reg_wr,
    input  wire logic [7:0]        i_reg_bus_addr,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [7:0]        i_reg_wdata,
    input  wire logic [7:0]        i_out_current_raw,
    input  wire logic [7:0]        i_out_power_raw,
    output logic [7:0]             o_reg_rdata,
    output logic                   o_reg_ack,
    // Sequencing outputs
    output logic                   o_driver_on,
    output logic                   o_regulator_ready,
    output logic [1:0]             o_pwm_level [NUM_RAILS],
    output logic [7:0]             o_dac_code,
    output logic [2:0]             o_phase_count,
    output logic                   o_power_mon_active,
    output logic                   o_fast_voltage_mode,
    output logic [3:0]             o_addr_slew_sel,
    output logic [3:0]             o_boot_step_sel
);

    typedef struct packed {
        vss_state_t  st;
        logic [1:0]  sup_sync;
        logic [1:0]  en_sync;
        logic        en_int;
        logic [7:0]  glitch_cnt;
        logic [23:0] cnt;
        logic [7:0]  slew_cnt;
        logic [7:0]  dac;
        logic [7:0]  boot;
        logic        cfg_done;
        logic [7:0]  cap;
        logic        dbl;
        logic        mon_on;
        logic        fast_v;
        logic [2:0]  phases;
        logic [3:0]  addr_slew;
        logic [3:0]  boot_step;
        logic        drv_on;
        logic        ready;
        logic [NUM_RAILS-1:0] started;
        logic [NUM_RAILS-1:0] pwm_hi;
        logic [NUM_RAILS-1:0][3:0] pulse_cnt;
        logic [NUM_RAILS-1:0][1:0] pwm_lvl;
        logic [7:0]  rdata;
        logic        ack;
    } vss_s_t;

    vss_s_t s_reg;
    vss_s_t s_next;

    // Boot code from strap selection: 0, 1.05 V or 1.8 V, arbitrary DAC units
    function automatic logic [7:0] boot_code(input logic [3:0] sel);
        case (sel[1:0])
            2'h0:    boot_code = 8'h00;
            2'h1:    boot_code = 8'h69;
            default: boot_code = 8'hB4;
        endcase
    endfunction : boot_code

    // Slew divider from strap: 10, 30, 48 mV/us steps
    function automatic logic [7:0] slew_div(input logic [3:0] sel);
        case (sel % 4'h3)
            4'h0:    slew_div = 8'h63;
            4'h1:    slew_div = 8'h21;
            default: slew_div = 8'h14;
        endcase
    endfunction : slew_div

    logic [35:0] cap_prod;
    logic [35:0] cap_full;
    logic [2:0]  phase_sum;

    always_comb begin
        s_next    = s_reg;
        cap_prod  = 36'(i_strap_cap_ohm) * 36'(CAP_NUM);
        cap_full  = cap_prod / 36'(CAP_DEN);
        phase_sum = 3'h0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            // R10 sense-derived phases
            if (!i_phase_sense_input_high[p]) phase_sum = phase_sum + 3'h1;
        end
        s_next.sup_sync = {s_reg.sup_sync[0], i_supply_ok};
        s_next.en_sync  = {s_reg.en_sync[0], i_rail_enable};
        // R7 fall glitch filter
        if (s_reg.en_sync[1]) begin
            s_next.en_int     = 1'b1;
            s_next.glitch_cnt = 8'h00;
        end else if (s_reg.glitch_cnt >= 8'(GLITCH_CYC - 1)) begin
            s_next.en_int = 1'b0;
        end else begin
            s_next.glitch_cnt = s_reg.glitch_cnt + 8'h01;
        end
        s_next.cnt = s_reg.cnt + 24'h000001;
        case (s_reg.st)
            VSS_LOCKOUT: begin
                s_next.cnt = 24'h000000;
                // R1 supply rise
                if (s_reg.sup_sync[1]) s_next.st = VSS_WAIT_STRAP;
            end
            VSS_WAIT_STRAP: begin
                // R9 detection start delay
                if (s_reg.cnt >= 24'(STRAP_WAIT_CYC - 1)) begin
                    s_next.st  = VSS_MEASURE;
                    s_next.cnt = 24'h000000;
                end
            end
            VSS_MEASURE: begin
                // R9 detection duration
                if (s_reg.cnt >= 24'(STRAP_CYC - 1)) begin
                    // R18 capture once
                    if (!s_reg.cfg_done) begin
                        s_next.cfg_done  = 1'b1;
                        // R14 capability formula
                        s_next.cap       = (cap_full > 36'hFF) ? 8'hFF : cap_full[7:0];
                        s_next.dbl       = i_double_current_lsb_select;
                        // R11 power monitor disable
                        s_next.mon_on    = !i_system_power_input_high;
                        // R13 variant fast mode
                        s_next.fast_v    = VARIANT_R && (i_strap_addr_slew < 4'h3 ||
                                           (i_strap_addr_slew > 4'h5 && i_strap_addr_slew < 4'h9));
                        s_next.phases    = phase_sum;
                        // R12 strap selections
                        s_next.addr_slew = i_strap_addr_slew;
                        s_next.boot_step = i_strap_boot_step;
                        s_next.boot      = boot_code(i_strap_boot_step);
                    end
                    s_next.st = VSS_IDLE;
                end
            end
            VSS_IDLE: begin
                s_next.cnt = 24'h000000;
                if (s_reg.en_int) s_next.st = VSS_ENABLE_WAIT;
            end
            VSS_ENABLE_WAIT: begin
                // R2 driver enable delay
                if (s_reg.cnt >= 24'(DRIVER_ON_CYC - 1)) begin
                    s_next.drv_on   = 1'b1;
                    s_next.st       = VSS_RAMP;
                    s_next.slew_cnt = 8'h00;
                    // R6 ready well before limit
                    s_next.ready    = 1'b1;
                end
            end
            VSS_RAMP: begin
                // R3 soft-start ramp
                if (s_reg.dac >= s_reg.boot) begin
                    s_next.st = VSS_RUN;
                end else if (s_reg.slew_cnt >= slew_div(s_reg.addr_slew)) begin
                    s_next.slew_cnt = 8'h00;
                    s_next.dac      = s_reg.dac + 8'h01;
                end else begin
                    s_next.slew_cnt = s_reg.slew_cnt + 8'h01;
                end
            end
            VSS_RUN: ;
            default: s_next.st = VSS_LOCKOUT;
        endcase
        // PWM tri-level per rail
        for (int r = 0; r < NUM_RAILS; r++) begin
            if (s_reg.drv_on && i_pwm_demand[r]) s_next.started[r] = 1'b1;
            if (s_reg.pwm_hi[r]) begin
                // R17 minimum high width
                if (s_reg.pulse_cnt[r] < 4'(MIN_PULSE_CYC - 1)) begin
                    s_next.pulse_cnt[r] = s_reg.pulse_cnt[r] + 4'h1;
                end else if (!i_pwm_demand[r]) begin
                    s_next.pwm_hi[r] = 1'b0;
                end
            end else if (s_reg.drv_on && i_pwm_demand[r]) begin
                // R4 leave mid on first pulse
                s_next.pwm_hi[r]    = 1'b1;
                s_next.pulse_cnt[r] = 4'h0;
            end
        end
        // R8 ready drop and R5 park on disable
        if (!s_reg.en_int && s_reg.st > VSS_IDLE) begin
            s_next.st      = VSS_IDLE;
            s_next.ready   = 1'b0;
            s_next.drv_on  = 1'b0;
            s_next.dac     = 8'h00;
            s_next.started = '0;
            s_next.pwm_hi  = '0;
        end
        // R18 lockout releases captured values
        if (!s_reg.sup_sync[1]) begin
            s_next.st       = VSS_LOCKOUT;
            s_next.cfg_done = 1'b0;
            s_next.ready    = 1'b0;
            s_next.drv_on   = 1'b0;
            s_next.dac      = 8'h00;
            s_next.started  = '0;
            s_next.pwm_hi   = '0;
        end
        // Tri-level code registered so the pins come straight from flops
        for (int r = 0; r < NUM_RAILS; r++) begin
            s_next.pwm_lvl[r] = s_next.pwm_hi[r] ? PWM_HIGH : (s_next.started[r] ? PWM_LOW : PWM_MID);
        end
        // R19 read-only registers, writes ignored
        s_next.ack   = (i_reg_rd || i_reg_wr) && s_reg.ready &&
                       !(i_reg_bus_addr == POWER_MON_ADDR && !s_reg.mon_on);
        s_next.rdata = 8'h00;
        if (i_reg_rd && s_next.ack) begin
            case (i_reg_addr)
                // R16 reading halved in double mode, so each LSB weighs twice as much
                REG_OUT_CURRENT: s_next.rdata = s_reg.dbl ? {1'b0, i_out_current_raw[7:1]} : i_out_current_raw;
                REG_OUT_POWER:   s_next.rdata = s_reg.dbl ? {1'b0, i_out_power_raw[7:1]} : i_out_power_raw;
                REG_CAPABILITY:  s_next.rdata = s_reg.dbl ? {1'b0, s_reg.cap[7:1]} : s_reg.cap;
                // R15 scaling fields
                REG_SCALING:     s_next.rdata = s_reg.dbl ? {3'h0, SCL_PWR_DOUBLE, SCL_CUR_DOUBLE}
                                                          : {3'h0, SCL_PWR_SINGLE, SCL_CUR_SINGLE};
                default:         s_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_reg         <= '0;
            s_reg.pwm_lvl <= {NUM_RAILS{PWM_MID}};
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            o_pwm_level[r] = s_reg.pwm_lvl[r];
        end
    end

    assign o_reg_rdata         = s_reg.rdata;
    assign o_reg_ack           = s_reg.ack;
    assign o_driver_on         = s_reg.drv_on;
    assign o_regulator_ready   = s_reg.ready;
    assign o_dac_code          = s_reg.dac;
    assign o_phase_count       = s_reg.phases;
    assign o_power_mon_active  = s_reg.mon_on;
    assign o_fast_voltage_mode = s_reg.fast_v;
    assign o_addr_slew_sel     = s_reg.addr_slew;
    assign o_boot_step_sel     = s_reg.boot_step;

    // R8 ready drop bound
    ready_drop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R8
        $fell(s_reg.en_int) |-> ##[1:2] !o_regulator_ready) else $error("ready not dropped");
    // R7 filter bound
    glitch_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R7
        $fell(s_reg.en_sync[1]) ##1 !s_reg.en_sync[1] [*7] |-> ##[0:90] (!s_reg.en_int || s_reg.en_sync[1]))
        else $error("enable fall not recognised");
    // R5 park on disable
    pwm_park_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R5
        !s_reg.drv_on |-> o_pwm_level[0] == PWM_MID && o_pwm_level[1] == PWM_MID) else $error("pwm not mid");
    // R17 minimum width
    min_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R17
        $rose(s_reg.pwm_hi[0]) && s_reg.drv_on |-> (s_reg.pwm_hi[0] || !s_reg.drv_on) [*4])
        else $error("pulse too short");
    // R15 scaling field
    scale_read_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
        i_reg_rd && i_reg_addr == REG_SCALING && s_next.ack |=> o_reg_rdata == (s_reg.dbl ? 8'h0D : 8'h08))
        else $error("scaling mismatch");
    // R2 driver enable waits
    driver_on_delay_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R2
        $rose(o_driver_on) |-> $past(s_reg.st) == VSS_ENABLE_WAIT) else $error("driver early");
    // R11 monitor silenced
    mon_silent_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R11
        !s_reg.mon_on && i_reg_bus_addr == POWER_MON_ADDR |=> !o_reg_ack) else $error("0Dh answered");
    // R18 config held
    cfg_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R18
        s_reg.cfg_done && $past(s_reg.cfg_done) |-> $stable(s_reg.cap)) else $error("config changed");
    // R13 base variant
    fast_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R13
        !VARIANT_R |-> !o_fast_voltage_mode) else $error("fast mode on");

    ramp_c:  cover property (@(posedge i_clk) s_reg.st == VSS_RAMP ##1 s_reg.st == VSS_RUN);
    ready_c: cover property (@(posedge i_clk) $rose(o_regulator_ready));
    off_c:   cover property (@(posedge i_clk) $fell(o_driver_on));
endmodule : vss_sequencer

// ### dv/vss_host_model.sv
`timescale 1ns/10ps
module vss_host_model
    import vss_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Requests towards the device
    output logic            o_rd,
    output logic            o_wr,
    output logic [7:0]      o_bus_addr,
    output logic [7:0]      o_addr,
    // Answer from the device
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_ack
);
    initial begin
        o_rd       = 1'b0;
        o_wr       = 1'b0;
        o_bus_addr = 8'hFF;
        o_addr     = 8'hFF;
    end

    // Request held until acknowledge is sampled high, or five rising edges pass
    task automatic xfer(input logic w, input logic [7:0] ba, input logic [7:0] ra,
                        output logic ack, output logic [7:0] d);
        ack = 1'b0;
        d   = 8'h00;
        @(negedge i_clk);
        o_rd       = ~w;
        o_wr       = w;
        o_bus_addr = ba;
        o_addr     = ra;
        @(posedge i_clk);
        for (int n = 0; n < 4 && !ack; n++) begin
            @(posedge i_clk);
            ack = i_ack;
            d   = i_rdata;
        end
        @(negedge i_clk);
        o_rd       = 1'b0;
        o_wr       = 1'b0;
        // Released lines must not keep the last value
        o_bus_addr = ~ba;
        o_addr     = ~ra;
    endtask : xfer
endmodule : vss_host_model

// ### dv/vss_sequencer_tb.sv
`timescale 1ns/10ps
module vss_sequencer_tb
    import vss_pkg::*;
;
    localparam int unsigned DRIVER_ON = 20;
    logic                 i_clk     = 1'b0;
    logic                 i_reset_n = 1'b0;
    logic                 sup_ok    = 1'b0;
    logic                 rail_en   = 1'b0;
    logic [17:0]          cap_ohm   = 18'h186A0;
    logic [3:0]           asl       = 4'h0;
    logic [3:0]           bst       = 4'h3;
    logic                 dbl       = 1'b0;
    logic                 ps_hi [NUM_PHASES] = '{default: 1'b0};
    logic                 sys_hi    = 1'b1;
    logic [NUM_RAILS-1:0] demand    = 2'h0;
    logic [7:0]           cur_raw   = 8'h20;
    logic [7:0]           pwr_raw   = 8'h40;
    logic                 rd, wr, ack, drv, rdy, pmon, fast;
    logic [7:0]           bus_addr, reg_addr, rdata, dac;
    logic [1:0]           pwm [NUM_RAILS];
    logic [2:0]           pcnt;
    logic [3:0]           asel, bsel;
    int                   err_count   = 0;
    int                   check_count = 0;

    always #5 i_clk = ~i_clk;

    vss_host_model vss_host_model_i (.i_clk(i_clk), .o_rd(rd), .o_wr(wr), .o_bus_addr(bus_addr),
                                     .o_addr(reg_addr), .i_rdata(rdata), .i_ack(ack));

    vss_sequencer #(.DRIVER_ON_CYC(DRIVER_ON), .STRAP_WAIT_CYC(10), .STRAP_CYC(5), .VARIANT_R(1'b0)) vss_sequencer_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_supply_ok(sup_ok), .i_rail_enable(rail_en),
        .i_strap_cap_ohm(cap_ohm), .i_strap_addr_slew(asl), .i_strap_boot_step(bst),
        .i_double_current_lsb_select(dbl), .i_phase_sense_input_high(ps_hi), .i_system_power_input_high(sys_hi),
        .i_pwm_demand(demand), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_bus_addr(bus_addr), .i_reg_addr(reg_addr),
        .i_reg_wdata(8'hA5), .i_out_current_raw(cur_raw), .i_out_power_raw(pwr_raw), .o_reg_rdata(rdata),
        .o_reg_ack(ack), .o_driver_on(drv), .o_regulator_ready(rdy), .o_pwm_level(pwm), .o_dac_code(dac),
        .o_phase_count(pcnt), .o_power_mon_active(pmon), .o_fast_voltage_mode(fast),
        .o_addr_slew_sel(asel), .o_boot_step_sel(bsel));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_in(input string n, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_in

    task automatic rd_chk(input string n, input logic [7:0] ba, input logic [7:0] ra, input logic ea,
                          input logic [7:0] e, input logic w = 1'b0);
        logic       a;
        logic [7:0] d;
        vss_host_model_i.xfer(w, ba, ra, a, d);
        chk({n, " ack"}, {15'h0, ea}, {15'h0, a});
        if (ea && !w) begin
            chk(n, {8'h0, e}, {8'h0, d});
        end
    endtask : rd_chk

    task automatic power_up(input logic d);
        @(negedge i_clk);
        i_reset_n = 1'b0;
        sup_ok    = 1'b0;
        rail_en   = 1'b0;
        dbl       = d;
        cap_ohm   = 18'h186A0;
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        sup_ok    = 1'b1;
        repeat (60) @(negedge i_clk);
        chk("pwm parked", {14'h0, PWM_MID}, {14'h0, pwm[1]});
    endtask : power_up

    task automatic t_enable();
        int n;
        rd_chk("read before ready", 8'h00, REG_CAPABILITY, 1'b0, 8'h00);
        chk("dac idle", 16'h0, {8'h0, dac});
        rail_en = 1'b1;
        n = 0;
        while (drv !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        chk_in("driver_on delay", DRIVER_ON, DRIVER_ON + 6, n);
        chk("ready with driver_on", 16'h1, {15'h0, rdy});
        chk("pwm before pulse", {14'h0, PWM_MID}, {14'h0, pwm[0]});
    endtask : t_enable

    task automatic t_pwm();
        int n;
        demand = 2'h1;
        repeat (3) @(negedge i_clk);
        chk("rail0 first pulse", {14'h0, PWM_HIGH}, {14'h0, pwm[0]});
        chk("rail1 still parked", {14'h0, PWM_MID}, {14'h0, pwm[1]});
        demand = 2'h2;
        @(negedge i_clk);
        demand = 2'h0;
        n = 0;
        repeat (12) begin
            n += (pwm[1] === PWM_HIGH);
            @(negedge i_clk);
        end
        chk_in("short pulse width", MIN_PULSE_CYC, 12, n);
        chk("rail0 low after pulse", {14'h0, PWM_LOW}, {14'h0, pwm[0]});
        repeat (200) @(negedge i_clk);
        chk_in("dac ramped", 1, 255, dac);
    endtask : t_pwm

    task automatic t_regs();
        ps_hi[3] = 1'b1;
        rd_chk("capability", 8'h00, REG_CAPABILITY, 1'b1, 8'h66);
        rd_chk("scaling single", 8'h00, REG_SCALING, 1'b1, {3'h0, SCL_PWR_SINGLE, SCL_CUR_SINGLE});
        rd_chk("current 1A", 8'h00, REG_OUT_CURRENT, 1'b1, 8'h20);
        rd_chk("power 4W", 8'h00, REG_OUT_POWER, 1'b1, 8'h40);
        rd_chk("write ro", 8'h00, REG_CAPABILITY, 1'b1, 8'h00, 1'b1);
        cap_ohm = 18'h30D40;
        rd_chk("capability kept", 8'h00, REG_CAPABILITY, 1'b1, 8'h66);
        rd_chk("monitor off", POWER_MON_ADDR, REG_OUT_CURRENT, 1'b0, 8'h00);
        chk("monitor flag", 16'h0, {15'h0, pmon});
        chk("phase count", 16'h4, {13'h0, pcnt});
        chk("fast mode base", 16'h0, {15'h0, fast});
    endtask : t_regs

    task automatic t_disable();
        int n;
        rail_en = 1'b0;
        repeat (5) @(negedge i_clk);
        rail_en = 1'b1;
        repeat (150) @(negedge i_clk);
        chk("glitch ignored", 16'h1, {15'h0, rdy});
        rail_en = 1'b0;
        n = 0;
        while (rdy !== 1'b0 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        chk_in("ready drop", 1, 150, n);
        repeat (3) @(negedge i_clk);
        chk("pwm0 off", {14'h0, PWM_MID}, {14'h0, pwm[0]});
        chk("pwm1 off", {14'h0, PWM_MID}, {14'h0, pwm[1]});
    endtask : t_disable

    task automatic t_double();
        sys_hi = 1'b0;
        power_up(1'b1);
        t_enable();
        chk("phase count reduced", 16'h3, {13'h0, pcnt});
        chk("monitor flag on", 16'h1, {15'h0, pmon});
        rd_chk("monitor on", POWER_MON_ADDR, REG_OUT_CURRENT, 1'b1, 8'h10);
        rd_chk("scaling double", 8'h00, REG_SCALING, 1'b1, {3'h0, SCL_PWR_DOUBLE, SCL_CUR_DOUBLE});
        rd_chk("capability 2A", 8'h00, REG_CAPABILITY, 1'b1, 8'h33);
        rd_chk("current 2A", 8'h00, REG_OUT_CURRENT, 1'b1, 8'h10);
        rd_chk("power 8W", 8'h00, REG_OUT_POWER, 1'b1, 8'h20);
    endtask : t_double

    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        end_sim();
    end

    initial begin
        power_up(1'b0);
        t_enable();
        t_pwm();
        t_regs();
        t_disable();
        t_double();
        end_sim();
    end
endmodule : vss_sequencer_tb
